// File: rtl/pwm_pkg.sv
// Register map, field layout and shared types of the pulse-width timer
package pwm_pkg;

  localparam int NUM_MATCH = 7;
  localparam int NUM_OUT   = 6;

  // Byte addresses of the register bank
  localparam logic [31:0] ADDR_IRQ_FLAGS     = 32'hE001_4000;
  localparam logic [31:0] ADDR_TIMER_CONTROL = 32'hE001_4004;
  localparam logic [31:0] ADDR_TIMER_COUNT   = 32'hE001_4008;
  localparam logic [31:0] ADDR_PRESCALE_LIM  = 32'hE001_400C;
  localparam logic [31:0] ADDR_PRESCALE_CNT  = 32'hE001_4010;
  localparam logic [31:0] ADDR_MATCH_ACTION  = 32'hE001_4014;
  localparam logic [31:0] ADDR_COMPARE [NUM_MATCH] = '{
    32'hE001_4018, 32'hE001_401C, 32'hE001_4020, 32'hE001_4024,
    32'hE001_4040, 32'hE001_4044, 32'hE001_4048};
  localparam logic [31:0] ADDR_OUTPUT_CTRL   = 32'hE001_404C;
  localparam logic [31:0] ADDR_LATCH_ENABLE  = 32'hE001_4050;

  localparam logic [31:0] RESET_VAL = 32'h0000_0000;

  // Timer control fields
  localparam int          TCR_EN_BIT  = 0;
  localparam int          TCR_RST_BIT = 1;
  localparam int          TCR_PWM_BIT = 3;
  localparam logic [31:0] TCR_MASK    = 32'h0000_000B;

  // Match action control: three bits per channel
  localparam int          MCR_FIELD_W  = 3;
  localparam int          MCR_INT_OFS  = 0;
  localparam int          MCR_RST_OFS  = 1;
  localparam int          MCR_STOP_OFS = 2;
  localparam logic [31:0] MCR_MASK     = 32'h001F_FFFF;

  // Interrupt flag bit position of each match channel
  localparam int IRQ_POS [NUM_MATCH] = '{0, 1, 2, 3, 8, 9, 10};

  // Output control: edge select at bit n, output enable at bit 8+n
  localparam int          PCR_SEL_LSB = 0;
  localparam int          PCR_ENA_LSB = 8;
  localparam logic [31:0] PCR_MASK    = 32'h0000_7E7C;

  localparam logic [31:0] LER_MASK = 32'h0000_007F;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// File: rtl/pulse_channel.sv
// One pulse output flip-flop with set, clear and output enable
`timescale 1ns/10ps
module pulse_channel (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  input  wire logic en_i,
  output logic      pulse_o
);

  logic state_ff;
  logic nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (clr_i) begin
      nxt_state = 1'b0;
    end else if (set_i) begin
      nxt_state = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_ff <= 1'b0;
      pulse_o  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // Disabled output parks low but the edge state keeps tracking
      pulse_o  <= en_i & nxt_state;
    end
  end

  clear_wins_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    clr_i |=> !pulse_o)
    else $error("clear did not take precedence over set");

  set_drives_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    set_i && !clr_i && en_i |=> pulse_o)
    else $error("set did not drive output high");

endmodule

// File: rtl/pwm_timer.sv
// Pulse-width timer: prescaler, timer counter, seven matches, six outputs
`timescale 1ns/10ps

// Notes on behaviour
// - Flag set when channel raises interrupt
// - Writing one clears flag, zero ignored
// - Flags at bits 0-3 and 8-10
// - Timer advances every prescale plus one cycles
// - Prescaler counts to limit, then timer increments
// - Prescale counter is software readable and writable
// - Timer control disables or resets counting
// - Match performs enabled interrupt, reset, stop
// - Match 0 sets single-edge outputs and output 1
// - Match n clears output n
// - Match n sets double-edge output n+1
// - Control register enables outputs, selects edge mode
// - Latch enable releases new match values
// - All used register bits reset to zero
// - Shadowed match applied on match 0 after latch
// - Control bit 0 counts, bit 1 holds reset
// - Timer wraps from all ones silently
// - Clear beats set on same output
module pwm_timer (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire pwm_pkg::reg_req_t reg_req_i,
  output logic [31:0]            reg_rdata_o,
  output logic                   irq_o,
  output logic [6:1]             pulse_out_o
);

  logic [31:0] tcr_ff;
  logic [31:0] tc_ff;
  logic [31:0] pr_ff;
  logic [31:0] pc_ff;
  logic [31:0] mcr_ff;
  logic [31:0] pcr_ff;
  logic [31:0] ler_ff;
  logic [31:0] mv_ff [pwm_pkg::NUM_MATCH];
  logic [31:0] am_ff [pwm_pkg::NUM_MATCH];
  logic [6:0]  flag_ff;
  logic        tc_new_ff;
  logic        irq_ff;

  logic [31:0] nxt_tc;
  logic [31:0] nxt_pc;
  logic [6:0]  nxt_flag;
  logic [31:0] nxt_rdata;
  logic [6:0]  eq;
  logic [6:0]  match;
  logic [6:0]  act_int;
  logic [6:0]  act_rst;
  logic [6:0]  act_stop;
  logic [6:0]  wr_mv;
  logic [6:0]  w1c;
  logic        wr_irq;
  logic        wr_tcr;
  logic        wr_tc;
  logic        wr_pr;
  logic        wr_pc;
  logic        wr_mcr;
  logic        wr_pcr;
  logic        wr_ler;
  logic        pwm_en;
  logic        stop_evt;
  logic        run_go;
  logic        tick;
  logic        hit_rst;

  // Register write decode
  assign wr_irq = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_IRQ_FLAGS);
  assign wr_tcr = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_TIMER_CONTROL);
  assign wr_tc  = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_TIMER_COUNT);
  assign wr_pr  = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_PRESCALE_LIM);
  assign wr_pc  = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_PRESCALE_CNT);
  assign wr_mcr = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_MATCH_ACTION);
  assign wr_pcr = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_OUTPUT_CTRL);
  assign wr_ler = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_LATCH_ENABLE);

  assign pwm_en = tcr_ff[pwm_pkg::TCR_PWM_BIT];

  // Per-channel decode of match fields and compares
  always_comb begin
    for (int i = 0; i < pwm_pkg::NUM_MATCH; i++) begin
      wr_mv[i]    = reg_req_i.wr && (reg_req_i.addr == pwm_pkg::ADDR_COMPARE[i]);
      w1c[i]      = wr_irq && reg_req_i.wdata[pwm_pkg::IRQ_POS[i]];
      act_int[i]  = mcr_ff[i * pwm_pkg::MCR_FIELD_W + pwm_pkg::MCR_INT_OFS];
      act_rst[i]  = mcr_ff[i * pwm_pkg::MCR_FIELD_W + pwm_pkg::MCR_RST_OFS];
      act_stop[i] = mcr_ff[i * pwm_pkg::MCR_FIELD_W + pwm_pkg::MCR_STOP_OFS];
      eq[i]       = (tc_ff == am_ff[i]);
    end
  end

  // One event per new timer value; a halted timer does not retrigger
  assign match    = eq & {7{tc_new_ff}};
  assign stop_evt = |(match & act_stop);
  assign hit_rst  = |(eq & act_rst);
  assign run_go   = tcr_ff[pwm_pkg::TCR_EN_BIT] && !tcr_ff[pwm_pkg::TCR_RST_BIT] && !stop_evt;
  assign tick     = run_go && (pc_ff == pr_ff);

  always_comb begin
    nxt_pc = pc_ff;
    nxt_tc = tc_ff;
    if (tcr_ff[pwm_pkg::TCR_RST_BIT]) begin
      nxt_pc = pwm_pkg::RESET_VAL;
      nxt_tc = pwm_pkg::RESET_VAL;
    end else begin
      if (wr_pc) begin
        nxt_pc = reg_req_i.wdata;
      end else if (tick) begin
        nxt_pc = pwm_pkg::RESET_VAL;
      end else if (run_go) begin
        nxt_pc = pc_ff + 32'h0000_0001;
      end
      if (wr_tc) begin
        nxt_tc = reg_req_i.wdata;
      end else if (tick && hit_rst) begin
        nxt_tc = pwm_pkg::RESET_VAL;
      end else if (tick) begin
        // Wraps through zero with no flag raised
        nxt_tc = tc_ff + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pc_ff     <= pwm_pkg::RESET_VAL;
      tc_ff     <= pwm_pkg::RESET_VAL;
      tc_new_ff <= 1'b0;
    end else begin
      pc_ff     <= nxt_pc;
      tc_ff     <= nxt_tc;
      tc_new_ff <= (nxt_tc != tc_ff);
    end
  end

  // Timer control; a software write wins over a stop in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tcr_ff <= pwm_pkg::RESET_VAL;
    end else if (wr_tcr) begin
      tcr_ff <= reg_req_i.wdata & pwm_pkg::TCR_MASK;
    end else if (stop_evt) begin
      tcr_ff[pwm_pkg::TCR_EN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pr_ff  <= pwm_pkg::RESET_VAL;
      mcr_ff <= pwm_pkg::RESET_VAL;
      pcr_ff <= pwm_pkg::RESET_VAL;
    end else begin
      if (wr_pr) begin
        pr_ff <= reg_req_i.wdata;
      end
      if (wr_mcr) begin
        mcr_ff <= reg_req_i.wdata & pwm_pkg::MCR_MASK;
      end
      if (wr_pcr) begin
        pcr_ff <= reg_req_i.wdata & pwm_pkg::PCR_MASK;
      end
    end
  end

  // Written match values and the shadows the comparators use
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < pwm_pkg::NUM_MATCH; i++) begin
        mv_ff[i] <= pwm_pkg::RESET_VAL;
        am_ff[i] <= pwm_pkg::RESET_VAL;
      end
    end else begin
      for (int i = 0; i < pwm_pkg::NUM_MATCH; i++) begin
        if (wr_mv[i]) begin
          mv_ff[i] <= reg_req_i.wdata;
        end
        // Timer mode takes new values at once, modulation mode at cycle end
        if (!pwm_en || (match[0] && ler_ff[i])) begin
          am_ff[i] <= mv_ff[i];
        end
      end
    end
  end

  // Latch bits drop once consumed; a fresh write in that cycle survives
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ler_ff <= pwm_pkg::RESET_VAL;
    end else if (wr_ler) begin
      ler_ff <= reg_req_i.wdata & pwm_pkg::LER_MASK;
    end else if (pwm_en && match[0]) begin
      ler_ff <= pwm_pkg::RESET_VAL;
    end
  end

  // Set wins over a write-one clear arriving in the same cycle
  assign nxt_flag = (flag_ff & ~w1c) | (match & act_int);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      flag_ff <= 7'h00;
      irq_ff  <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      irq_ff  <= |nxt_flag;
    end
  end

  assign irq_o = irq_ff;

  // Read mux; reserved bits read as zero
  always_comb begin
    nxt_rdata = pwm_pkg::RESET_VAL;
    case (reg_req_i.addr)
      pwm_pkg::ADDR_IRQ_FLAGS: begin
        for (int i = 0; i < pwm_pkg::NUM_MATCH; i++) begin
          nxt_rdata[pwm_pkg::IRQ_POS[i]] = flag_ff[i];
        end
      end
      pwm_pkg::ADDR_TIMER_CONTROL: nxt_rdata = tcr_ff;
      pwm_pkg::ADDR_TIMER_COUNT:   nxt_rdata = tc_ff;
      pwm_pkg::ADDR_PRESCALE_LIM:  nxt_rdata = pr_ff;
      pwm_pkg::ADDR_PRESCALE_CNT:  nxt_rdata = pc_ff;
      pwm_pkg::ADDR_MATCH_ACTION:  nxt_rdata = mcr_ff;
      pwm_pkg::ADDR_OUTPUT_CTRL:   nxt_rdata = pcr_ff;
      pwm_pkg::ADDR_LATCH_ENABLE:  nxt_rdata = ler_ff;
      default: begin
        for (int i = 0; i < pwm_pkg::NUM_MATCH; i++) begin
          if (reg_req_i.addr == pwm_pkg::ADDR_COMPARE[i]) begin
            nxt_rdata = mv_ff[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= pwm_pkg::RESET_VAL;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // Output flip-flops: set and clear sources per edge mode
  for (genvar n = 1; n <= pwm_pkg::NUM_OUT; n++) begin : g_out
    logic dbl;
    logic set;
    // Output 1 has match 0 as both neighbours, so it is single-edge either way
    assign dbl = (n > 1) && pcr_ff[pwm_pkg::PCR_SEL_LSB + n];
    assign set = dbl ? match[n - 1] : match[0];
    pulse_channel i_pulse_channel (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .set_i   (set),
      .clr_i   (match[n]),
      .en_i    (pcr_ff[pwm_pkg::PCR_ENA_LSB + n]),
      .pulse_o (pulse_out_o[n])
    );
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  flag_set_a: assert property (match[1] && act_int[1] |=> flag_ff[1])
    else $error("match interrupt flag not set");

  flag_clear_a: assert property (w1c[4] && !(match[4] && act_int[4]) |=> !flag_ff[4])
    else $error("write one did not clear flag");

  flag_keep_a: assert property (wr_irq && flag_ff[0] && !reg_req_i.wdata[0] |=> flag_ff[0])
    else $error("write zero changed flag");

  irq_hole_a: assert property (reg_req_i.rd && reg_req_i.addr == pwm_pkg::ADDR_IRQ_FLAGS
    |=> reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[10:8] == $past(flag_ff[6:4])
      && reg_rdata_o[3:0] == $past(flag_ff[3:0]))
    else $error("flag register layout wrong");

  tc_step_a: assert property (tick && !hit_rst && !wr_tc |=> tc_ff == $past(tc_ff) + 32'h0000_0001)
    else $error("timer did not advance on prescale terminal");

  pc_wrap_a: assert property (tick && !wr_pc |=> pc_ff == 32'h0000_0000)
    else $error("prescale counter did not restart");

  tc_hold_a: assert property (!tcr_ff[pwm_pkg::TCR_EN_BIT] && !wr_tc && !tcr_ff[pwm_pkg::TCR_RST_BIT]
    |=> $stable(tc_ff))
    else $error("disabled timer moved");

  cnt_reset_a: assert property (tcr_ff[pwm_pkg::TCR_RST_BIT] |=> tc_ff == 32'h0 && pc_ff == 32'h0)
    else $error("counters not held in reset");

  // Software writes in the stop cycle legally move the counters or the enable bit, so they are excluded
  stop_evt_a: assert property (stop_evt && !wr_tcr && !wr_tc && !wr_pc && !tcr_ff[pwm_pkg::TCR_RST_BIT]
    |=> !tcr_ff[pwm_pkg::TCR_EN_BIT] && $stable(tc_ff) && $stable(pc_ff))
    else $error("stop on match did not halt timer");

  wrap_quiet_a: assert property (tick && tc_ff == 32'hFFFF_FFFF && !hit_rst && !wr_tc
    |=> tc_ff == 32'h0)
    else $error("timer did not wrap to zero");

  shadow_hold_a: assert property (pwm_en && !match[0] |=> $stable(am_ff[1]))
    else $error("shadow changed outside match 0");

  irq_out_a: assert property (irq_o == (|flag_ff))
    else $error("interrupt output disagrees with flags");

endmodule

// File: tb/pulse_load.sv
// Load model on the six pulse pins: counts high cycles per pin
`timescale 1ns/10ps
module pulse_load (
  input  wire logic            clock_i,
  input  wire logic            clr_i,
  input  wire logic [6:1]      pulse_i,
  output logic      [6:1][7:0] high_cnt_o
);
  // Passive load, nothing flows back into the block
  always_ff @(posedge clock_i) begin
    for (int i = 1; i <= 6; i++) begin
      if (clr_i) begin
        high_cnt_o[i] <= 8'h00;
      end else begin
        high_cnt_o[i] <= high_cnt_o[i] + {7'h00, pulse_i[i]};
      end
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench of the pulse-width timer
`timescale 1ns/10ps
module tb_top;
  logic              clock_i;
  logic              rst_n_i;
  pwm_pkg::reg_req_t req;
  logic [31:0]       reg_rdata_o;
  logic              irq_o;
  logic [6:1]        pulse_out_o;
  logic              clr;
  logic [6:1][7:0]   high_cnt;
  int                miscompares;
  int                tests_run;
  int                cycles;

  pwm_timer i_pwm_timer (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_req_i(req),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .pulse_out_o(pulse_out_o));
  pulse_load i_pulse_load (.clock_i(clock_i), .clr_i(clr), .pulse_i(pulse_out_o), .high_cnt_o(high_cnt));

  always #2.5 clock_i = ~clock_i;

  // Whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    req <= '0;
  endtask

  // Read data holds until the next read request, so a late sample is safe
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clock_i);
    req <= '0;
    @(posedge clock_i);
    #1 check(reg_rdata_o, exp);
  endtask

  task automatic test_reset_values();
    logic [31:0] regs [15] = '{pwm_pkg::ADDR_IRQ_FLAGS, pwm_pkg::ADDR_TIMER_CONTROL, pwm_pkg::ADDR_TIMER_COUNT,
      pwm_pkg::ADDR_PRESCALE_LIM, pwm_pkg::ADDR_PRESCALE_CNT, pwm_pkg::ADDR_MATCH_ACTION,
      pwm_pkg::ADDR_COMPARE[0], pwm_pkg::ADDR_COMPARE[1], pwm_pkg::ADDR_COMPARE[2], pwm_pkg::ADDR_COMPARE[3],
      pwm_pkg::ADDR_COMPARE[4], pwm_pkg::ADDR_COMPARE[5], pwm_pkg::ADDR_COMPARE[6],
      pwm_pkg::ADDR_OUTPUT_CTRL, pwm_pkg::ADDR_LATCH_ENABLE};
    foreach (regs[i]) rd_chk(regs[i], pwm_pkg::RESET_VAL);
    rd_chk(32'hE001_4028, 32'h0000_0000);
    check({25'h0, irq_o, pulse_out_o}, 32'h0000_0000);
    $display("test reset_values done");
  endtask

  task automatic test_read_write();
    wr(pwm_pkg::ADDR_PRESCALE_CNT, 32'h0000_0005);
    rd_chk(pwm_pkg::ADDR_PRESCALE_CNT, 32'h0000_0005);
    wr(pwm_pkg::ADDR_COMPARE[6], 32'hA5A5_5A5A);
    rd_chk(pwm_pkg::ADDR_COMPARE[6], 32'hA5A5_5A5A);
    wr(pwm_pkg::ADDR_LATCH_ENABLE, 32'h0000_007F);
    rd_chk(pwm_pkg::ADDR_LATCH_ENABLE, 32'h0000_007F);
    wr(pwm_pkg::ADDR_LATCH_ENABLE, 32'h0000_0000);
    $display("test read_write done");
  endtask

  task automatic test_prescale();
    wr(pwm_pkg::ADDR_PRESCALE_LIM, 32'h0000_0002);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0002);
    rd_chk(pwm_pkg::ADDR_PRESCALE_CNT, 32'h0000_0000);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0001);
    // Counting edges between the two writes: 28 idle plus 2
    repeat (28) @(posedge clock_i);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0000);
    rd_chk(pwm_pkg::ADDR_TIMER_COUNT, 32'h0000_000A);
    rd_chk(pwm_pkg::ADDR_PRESCALE_CNT, 32'h0000_0000);
    repeat (5) @(posedge clock_i);
    rd_chk(pwm_pkg::ADDR_TIMER_COUNT, 32'h0000_000A);
    $display("test prescale done");
  endtask

  task automatic test_rollover();
    wr(pwm_pkg::ADDR_PRESCALE_LIM, 32'h0000_0000);
    wr(pwm_pkg::ADDR_TIMER_COUNT, 32'hFFFF_FFFF);
    wr(pwm_pkg::ADDR_MATCH_ACTION, 32'h0004_0000);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0001);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0000);
    rd_chk(pwm_pkg::ADDR_TIMER_COUNT, 32'h0000_0001);
    rd_chk(pwm_pkg::ADDR_IRQ_FLAGS, 32'h0000_0000);
    $display("test rollover done");
  endtask

  // Waits for output 1 to rise, then counts high cycles over three periods of ten
  task automatic count_window();
    int n;
    n = 0;
    #1;
    while (pulse_out_o[1] !== 1'b1 && n < 50) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    check({31'h0, pulse_out_o[1]}, 32'h0000_0001);
    @(posedge clock_i);
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    repeat (30) @(posedge clock_i);
    #1;
  endtask

  task automatic test_pwm_waves();
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0002);
    wr(pwm_pkg::ADDR_COMPARE[0], 32'h0000_0009);
    wr(pwm_pkg::ADDR_COMPARE[1], 32'h0000_0003);
    wr(pwm_pkg::ADDR_COMPARE[2], 32'h0000_0005);
    wr(pwm_pkg::ADDR_COMPARE[3], 32'h0000_0007);
    wr(pwm_pkg::ADDR_COMPARE[4], 32'h0000_0008);
    wr(pwm_pkg::ADDR_COMPARE[5], 32'h0000_0009);
    wr(pwm_pkg::ADDR_MATCH_ACTION, 32'h0000_100B);
    // Zeros kept in reserved bits of every control write
    wr(pwm_pkg::ADDR_OUTPUT_CTRL, 32'h0000_2E08);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0001);
    count_window();
    check({24'h0, high_cnt[1]}, 32'h0000_000C);
    check({24'h0, high_cnt[2]}, 32'h0000_0012);
    check({24'h0, high_cnt[3]}, 32'h0000_0006);
    check({24'h0, high_cnt[4]}, 32'h0000_0000);
    check({24'h0, high_cnt[5]}, 32'h0000_0000);
    check({31'h0, irq_o}, 32'h0000_0001);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0000);
    rd_chk(pwm_pkg::ADDR_IRQ_FLAGS, 32'h0000_0103);
    wr(pwm_pkg::ADDR_IRQ_FLAGS, 32'h0000_0002);
    rd_chk(pwm_pkg::ADDR_IRQ_FLAGS, 32'h0000_0101);
    wr(pwm_pkg::ADDR_IRQ_FLAGS, 32'h0000_0000);
    rd_chk(pwm_pkg::ADDR_IRQ_FLAGS, 32'h0000_0101);
    check({31'h0, irq_o}, 32'h0000_0001);
    wr(pwm_pkg::ADDR_IRQ_FLAGS, 32'h0000_0101);
    rd_chk(pwm_pkg::ADDR_IRQ_FLAGS, 32'h0000_0000);
    check({31'h0, irq_o}, 32'h0000_0000);
    $display("test pwm_waves done");
  endtask

  task automatic test_stop_on_match();
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0002);
    wr(pwm_pkg::ADDR_MATCH_ACTION, 32'h0000_0020);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0001);
    repeat (20) @(posedge clock_i);
    rd_chk(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0000);
    rd_chk(pwm_pkg::ADDR_TIMER_COUNT, 32'h0000_0003);
    $display("test stop_on_match done");
  endtask

  // Modulation mode: a new width waits for its latch bit and the next cycle start
  task automatic test_shadow_latch();
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_000A);
    wr(pwm_pkg::ADDR_MATCH_ACTION, 32'h0000_0002);
    wr(pwm_pkg::ADDR_COMPARE[1], 32'h0000_0006);
    rd_chk(pwm_pkg::ADDR_COMPARE[1], 32'h0000_0006);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0009);
    count_window();
    check({24'h0, high_cnt[1]}, 32'h0000_000C);
    check({24'h0, high_cnt[6]}, 32'h0000_0000);
    wr(pwm_pkg::ADDR_LATCH_ENABLE, 32'h0000_0002);
    repeat (20) @(posedge clock_i);
    rd_chk(pwm_pkg::ADDR_LATCH_ENABLE, 32'h0000_0000);
    count_window();
    check({24'h0, high_cnt[1]}, 32'h0000_0015);
    wr(pwm_pkg::ADDR_TIMER_CONTROL, 32'h0000_0000);
    $display("test shadow_latch done");
  endtask

  initial begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    req = '0;
    clr = 1'b0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    test_reset_values();
    test_read_write();
    test_prescale();
    test_rollover();
    test_pwm_waves();
    test_stop_on_match();
    test_shadow_latch();
    end_of_test();
  end
endmodule
